// ===== core/drb_code_buffer.sv
// Register file and double-buffered codes for three 10-bit reference converters.
//
// How it works
// R1: Justify set: high register bits 7..0 become code bits 9..2.
// R2: Justify clear: high bits 1..0 become code 9..8, bits 7..2 read zero.
// R3: Justify set: low bits 7..6 become code 1..0, bits 5..0 read zero.
// R4: Justify clear: low register bits 7..0 become code bits 7..0.
// R5: Load register: channel 5 at bit 4, channel 2 bit 1, channel 1 bit 0.
// R6: Writing 1 to a load bit copies high/low into the buffer, then self-clears.
// R7: Without a load, the buffer keeps its code whatever is written to high and low.
// R8: The converter receives the whole 10-bit buffered code as one word.
// R9: All implemented register bits reset to zero on every reset.
// R10: Unimplemented bits read zero and ignore writes.
// R11: Control bit 6 selects left (1) or right (0) justification.
// R12: High/low writes never reach the output; a load changes all ten bits together.
// R13: Reset disables each converter and clears its buffered code.
// R14: Control bit 7 enables the converter when 1.
// R15: Justification in force at the load decides how the code is assembled.
`timescale 1ns/100ps
`default_nettype none
`include "drb_defs.svh"

module drb_code_buffer
  import drb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [9:0] ch1_code_out,
  output logic [9:0] ch2_code_out,
  output logic [9:0] ch5_code_out,
  output logic ch1_enable_out,
  output logic ch2_enable_out,
  output logic ch5_enable_out,
  output logic ch1_pin1_output_enable_out,
  output logic ch2_pin1_output_enable_out,
  output logic ch5_pin1_output_enable_out,
  output logic ch1_pin2_output_enable_out,
  output logic ch2_pin2_output_enable_out,
  output logic ch5_pin2_output_enable_out,
  output logic [1:0] ch1_upper_source_select_out,
  output logic [1:0] ch2_upper_source_select_out,
  output logic [1:0] ch5_upper_source_select_out,
  output logic [1:0] ch1_lower_source_select_out,
  output logic [1:0] ch2_lower_source_select_out,
  output logic [1:0] ch5_lower_source_select_out
);

  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W must be at least 6 to reach every register");
  end

  if (`DRB_LD_CH1_BIT > 7 || `DRB_LD_CH2_BIT > 7 || `DRB_LD_CH5_BIT > 7) begin : g_ld_check
    $error("Load strobe positions must fall inside the low data byte");
  end

  if (`DRB_CH_STRIDE % 4 != 0) begin : g_stride_check
    $error("Channel stride must keep every register on its own word");
  end

  localparam int NCH = 3;
  localparam int LD_POS [NCH] = '{`DRB_LD_CH1_BIT, `DRB_LD_CH2_BIT, `DRB_LD_CH5_BIT}; // R5

  // Overlapping groups would alias two registers onto one word without any warning.
  if (`DRB_HIGH_BASE - `DRB_CTRL_BASE < NCH * `DRB_CH_STRIDE ||
      `DRB_LOW_BASE - `DRB_HIGH_BASE < NCH * `DRB_CH_STRIDE ||
      `DRB_LOAD_OFF - `DRB_LOW_BASE < NCH * `DRB_CH_STRIDE ||
      `DRB_CODE_BASE - `DRB_LOAD_OFF < 4) begin : g_map_check
    $error("Register groups overlap");
  end

  ////////////////////////////////////////////////////////////////////////////

  // Storage keeps only the bits that the current format implements.
  // Masking on the way in means a later format change never exposes stale ones;
  // the price is that a value written under one format is cut to that format.
  function automatic drb_byte_t mask_high(input logic fm, input drb_byte_t d);
    if (fm) begin
      mask_high = d; // R1
    end else begin
      mask_high = {6'h00, d[1:0]}; // R2
    end
  endfunction

  function automatic drb_byte_t mask_low(input logic fm, input drb_byte_t d);
    if (fm) begin
      mask_low = {d[7:6], 6'h00}; // R3
    end else begin
      mask_low = d; // R4
    end
  endfunction

  function automatic drb_code_t assemble(input logic fm, input drb_byte_t hi,
                                         input drb_byte_t lo);
    if (fm) begin
      assemble = {hi, lo[7:6]}; // R1 R3
    end else begin
      assemble = {hi[1:0], lo}; // R2 R4
    end
  endfunction

  function automatic logic [ADDR_W-1:0] chan_off(input logic [7:0] base, input int ch);
    logic [7:0] off;
    off = base + 8'(ch * `DRB_CH_STRIDE);
    chan_off = ADDR_W'(off);
  endfunction

  function automatic logic same_word(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    same_word = (a[ADDR_W-1:2] == b[ADDR_W-1:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  drb_byte_t ctrl [NCH];
  drb_byte_t high [NCH];
  drb_byte_t low [NCH];
  drb_code_t code_buf [NCH];
  logic [NCH-1:0] load_pend;
  logic [NCH-1:0] next_load_pend;

  logic [ADDR_W-1:0] waddr;
  drb_byte_t wbyte;
  logic wlane;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // A write commits in the cycle after both halves are held, and only while no
  // response is pending, so register updates and bvalid always rise together.
  assign do_write = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data are each held until both are present.
  // Separate holding lets a master offer address and data in either order.

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b1;
      waddr <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_axi_awready_out <= 1'b0;
      waddr <= s_axi_awaddr_in;
    end else if (do_write) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_wready_out <= 1'b1;
      wbyte <= `DRB_BYTE_RST;
      wlane <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_axi_wready_out <= 1'b0;
      wbyte <= s_axi_wdata_in[7:0];
      wlane <= s_axi_wstrb_in[0];
    end else if (do_write) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  always_comb begin
    wr_hit = same_word(waddr, ADDR_W'(`DRB_LOAD_OFF));
    for (int ch = 0; ch < NCH; ch++) begin
      if (same_word(waddr, chan_off(`DRB_CTRL_BASE, ch)) ||
          same_word(waddr, chan_off(`DRB_HIGH_BASE, ch)) ||
          same_word(waddr, chan_off(`DRB_LOW_BASE, ch)) ||
          same_word(waddr, chan_off(`DRB_CODE_BASE, ch))) begin
        wr_hit = 1'b1;
      end
    end
  end

  // The read-only code registers accept writes silently with OKAY.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `DRB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_hit ? `DRB_RESP_OKAY : `DRB_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; only byte lane 0 carries data.
  // Every control bit is implemented, so control writes need no masking.

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int ch = 0; ch < NCH; ch++) begin
        ctrl[ch] <= `DRB_BYTE_RST; // R9 R13
        high[ch] <= `DRB_BYTE_RST; // R9
        low[ch] <= `DRB_BYTE_RST; // R9
      end
    end else if (do_write && wlane) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (same_word(waddr, chan_off(`DRB_CTRL_BASE, ch))) begin
          ctrl[ch] <= wbyte;
        end
        if (same_word(waddr, chan_off(`DRB_HIGH_BASE, ch))) begin
          high[ch] <= mask_high(ctrl[ch][`DRB_FM_BIT], wbyte); // R10 R11
        end
        if (same_word(waddr, chan_off(`DRB_LOW_BASE, ch))) begin
          low[ch] <= mask_low(ctrl[ch][`DRB_FM_BIT], wbyte); // R10 R11
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A load bit stays set for exactly one cycle, during which the buffer copies.
  // A fresh write of 1 always sets it again, so no request is lost.

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      next_load_pend[ch] = do_write && wlane && same_word(waddr, ADDR_W'(`DRB_LOAD_OFF)) &&
                           wbyte[LD_POS[ch]]; // R5 R6 R10
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      load_pend <= '0; // R9
    end else begin
      load_pend <= next_load_pend; // R6
    end
  end

  // The buffer alone feeds the converter, so high/low writes never glitch it.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int ch = 0; ch < NCH; ch++) begin
        code_buf[ch] <= `DRB_CODE_RST; // R13
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (load_pend[ch]) begin
          code_buf[ch] <= assemble(ctrl[ch][`DRB_FM_BIT], high[ch], low[ch]); // R6 R12 R15
        end
      end
    end
  end // R7

  ////////////////////////////////////////////////////////////////////////////
  // Read path answers one cycle after the address is taken.
  // A load bit lives for one cycle only, so a read of the load register shows it
  // only when the read is taken in that very cycle.

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b0;
    if (same_word(s_axi_araddr_in, ADDR_W'(`DRB_LOAD_OFF))) begin
      rd_hit = 1'b1;
      for (int ch = 0; ch < NCH; ch++) begin
        rd_word[LD_POS[ch]] = load_pend[ch]; // R5 R10
      end
    end
    for (int ch = 0; ch < NCH; ch++) begin
      if (same_word(s_axi_araddr_in, chan_off(`DRB_CTRL_BASE, ch))) begin
        rd_hit = 1'b1;
        rd_word[7:0] = ctrl[ch];
      end
      if (same_word(s_axi_araddr_in, chan_off(`DRB_HIGH_BASE, ch))) begin
        rd_hit = 1'b1;
        rd_word[7:0] = mask_high(ctrl[ch][`DRB_FM_BIT], high[ch]); // R2 R10
      end
      if (same_word(s_axi_araddr_in, chan_off(`DRB_LOW_BASE, ch))) begin
        rd_hit = 1'b1;
        rd_word[7:0] = mask_low(ctrl[ch][`DRB_FM_BIT], low[ch]); // R3 R10
      end
      if (same_word(s_axi_araddr_in, chan_off(`DRB_CODE_BASE, ch))) begin
        rd_hit = 1'b1;
        rd_word[9:0] = code_buf[ch];
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `DRB_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_word;
      s_axi_rresp_out <= rd_hit ? `DRB_RESP_OKAY : `DRB_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter-side outputs, each straight from its flip-flop.

  assign ch1_code_out = code_buf[0]; // R8
  assign ch2_code_out = code_buf[1]; // R8
  assign ch5_code_out = code_buf[2]; // R8

  assign ch1_enable_out = ctrl[0][`DRB_EN_BIT]; // R14
  assign ch2_enable_out = ctrl[1][`DRB_EN_BIT]; // R14
  assign ch5_enable_out = ctrl[2][`DRB_EN_BIT]; // R14

  assign ch1_pin1_output_enable_out = ctrl[0][`DRB_OE1_BIT];
  assign ch2_pin1_output_enable_out = ctrl[1][`DRB_OE1_BIT];
  assign ch5_pin1_output_enable_out = ctrl[2][`DRB_OE1_BIT];
  assign ch1_pin2_output_enable_out = ctrl[0][`DRB_OE2_BIT];
  assign ch2_pin2_output_enable_out = ctrl[1][`DRB_OE2_BIT];
  assign ch5_pin2_output_enable_out = ctrl[2][`DRB_OE2_BIT];

  assign ch1_upper_source_select_out = ctrl[0][`DRB_PSS_HI:`DRB_PSS_LO];
  assign ch2_upper_source_select_out = ctrl[1][`DRB_PSS_HI:`DRB_PSS_LO];
  assign ch5_upper_source_select_out = ctrl[2][`DRB_PSS_HI:`DRB_PSS_LO];
  assign ch1_lower_source_select_out = ctrl[0][`DRB_NSS_HI:`DRB_NSS_LO];
  assign ch2_lower_source_select_out = ctrl[1][`DRB_NSS_HI:`DRB_NSS_LO];
  assign ch5_lower_source_select_out = ctrl[2][`DRB_NSS_HI:`DRB_NSS_LO];

endmodule

`default_nettype wire

// ===== core/drb_defs.svh
// Register offsets, field positions and reset values of the converter code buffer.
`ifndef DRB_DEFS_SVH
`define DRB_DEFS_SVH

// Per-channel register groups; channel n sits at base + 4*n (n = 0,1,2 for 1,2,5).
`define DRB_CTRL_BASE 8'h00
`define DRB_HIGH_BASE 8'h0C
`define DRB_LOW_BASE 8'h18
`define DRB_LOAD_OFF 8'h24
`define DRB_CODE_BASE 8'h28
`define DRB_CH_STRIDE 8'h04

// Control register fields.
`define DRB_EN_BIT 7
`define DRB_FM_BIT 6
`define DRB_OE1_BIT 5
`define DRB_OE2_BIT 4
`define DRB_PSS_HI 3
`define DRB_PSS_LO 2
`define DRB_NSS_HI 1
`define DRB_NSS_LO 0

// Load strobe positions for channels 1, 2 and 5.
`define DRB_LD_CH1_BIT 0
`define DRB_LD_CH2_BIT 1
`define DRB_LD_CH5_BIT 4

`define DRB_BYTE_RST 8'h00
`define DRB_CODE_RST 10'h000

`define DRB_RESP_OKAY 2'h0
`define DRB_RESP_SLVERR 2'h2

`endif

// ===== core/drb_pkg.sv
// Types shared by the converter code buffer.
package drb_pkg;
  typedef logic [7:0] drb_byte_t;
  typedef logic [9:0] drb_code_t;
  typedef logic [1:0] drb_resp_t;
endpackage

// ===== sim/drb_code_buffer_properties.sv
// Bus handshake and code buffer properties of the converter code buffer.
`timescale 1ns/100ps
`default_nettype none
module drb_code_buffer_chk (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [9:0] ch1_code_out,
  input wire logic ch1_enable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////
  chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write not answered");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
    && $stable(s_axi_bresp_out)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
    && $stable(s_axi_rdata_out)) else $error("read data dropped");
  chk_rdata_upper: assert property (
    s_axi_rvalid_out |-> s_axi_rdata_out[31:10] == 22'h000000) else $error("upper bits set");
  // The buffer may only move on the edge after a completed write.
  chk_code_after_load: assert property (
    $changed(ch1_code_out) |-> $past(s_axi_bvalid_out)) else $error("code moved alone");
  chk_enable_by_write: assert property (
    $changed(ch1_enable_out) |-> $rose(s_axi_bvalid_out)) else $error("enable moved alone");
  chk_reset_clears: assert property (
    $fell(rst_in) |-> ch1_code_out == 10'h000 && !ch1_enable_out) else $error("reset kept");
  cover property ($changed(ch1_code_out));
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
  cover property ($rose(s_axi_rvalid_out));
endmodule
`default_nettype wire

// ===== sim/test_drb_code_buffer.sv
// Self-checking bench for the converter code buffer.
`timescale 1ns/100ps
`default_nettype none
module test_drb_code_buffer;
  logic clock_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, o;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [9:0] ch1_code_out, ch2_code_out, ch5_code_out;
  logic ch1_enable_out, ch2_enable_out, ch5_enable_out;
  logic ch1_pin1_output_enable_out, ch2_pin1_output_enable_out, ch5_pin1_output_enable_out;
  logic ch1_pin2_output_enable_out, ch2_pin2_output_enable_out, ch5_pin2_output_enable_out;
  logic [1:0] ch1_upper_source_select_out, ch2_upper_source_select_out;
  logic [1:0] ch5_upper_source_select_out, ch1_lower_source_select_out;
  logic [1:0] ch2_lower_source_select_out, ch5_lower_source_select_out;
  logic [7:0] ld [3] = '{8'h01, 8'h02, 8'h10};
  int error_cnt = 0;
  int comparisons = 0;
  bit slow_ready = 1'b0;
  drb_code_buffer dut_u (.*);
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= !slow_ready;
    do begin
      @(posedge clock_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out && !s_axi_bready_in) s_axi_bready_in <= 1'b1;
    end while (!(s_axi_bvalid_out && s_axi_bready_in));
    s_axi_bready_in <= 1'b0;
    chk({30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= !slow_ready;
    do begin
      @(posedge clock_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out && !s_axi_rready_in) s_axi_rready_in <= 1'b1;
    end while (!(s_axi_rvalid_out && s_axi_rready_in));
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rdata_out, ed);
    chk({30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask
  // Enable and code of one channel side by side, so one compare covers both.
  function automatic logic [31:0] out(input int i);
    if (i == 0) return {21'h0, ch1_enable_out, ch1_code_out};
    if (i == 1) return {21'h0, ch2_enable_out, ch2_code_out};
    return {21'h0, ch5_enable_out, ch5_code_out};
  endfunction
  // Enable, both pin enables and both source selects in control register order.
  function automatic logic [31:0] pins(input int i);
    if (i == 0) return {25'h0, ch1_enable_out, ch1_pin1_output_enable_out,
      ch1_pin2_output_enable_out, ch1_upper_source_select_out, ch1_lower_source_select_out};
    if (i == 1) return {25'h0, ch2_enable_out, ch2_pin1_output_enable_out,
      ch2_pin2_output_enable_out, ch2_upper_source_select_out, ch2_lower_source_select_out};
    return {25'h0, ch5_enable_out, ch5_pin1_output_enable_out,
      ch5_pin2_output_enable_out, ch5_upper_source_select_out, ch5_lower_source_select_out};
  endfunction
  task automatic print_verdict;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_in);
    error_cnt++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    s_axi_awaddr_in = 8'h00;
    s_axi_araddr_in = 8'h00;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hF;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 13; i++) rd(8'(4 * i), 32'h0, 2'h0);
    for (int i = 0; i < 3; i++) chk(out(i), 32'h0);
    $display("test reset values done");
    wr(8'h34, 32'hFF, 2'h2);
    rd(8'h34, 32'h0, 2'h2);
    $display("test unmapped done");
    for (int i = 0; i < 3; i++) begin
      o = 8'(4 * i);
      wr(o + 8'h0C, 32'hFF, 2'h0);
      rd(o + 8'h0C, 32'h03, 2'h0);
      wr(o + 8'h18, 32'hA5 + i, 2'h0);
      rd(o + 8'h18, 32'hA5 + i, 2'h0);
      chk(out(i), 32'h0);
    end
    wr(8'h24, 32'hEC, 2'h0);
    rd(8'h24, 32'h0, 2'h0);
    for (int j = 0; j < 3; j++) begin
      wr(8'h24, {24'h0, ld[j]}, 2'h0);
      @(negedge clock_in);
      for (int k = 0; k < 3; k++) chk(out(k), k <= j ? 32'h3A5 + k : 32'h0);
    end
    rd(8'h24, 32'h0, 2'h0);
    $display("test right justified load done");
    for (int i = 0; i < 3; i++) begin
      o = 8'(4 * i);
      wr(o, 32'hC0, 2'h0);
      wr(o + 8'h0C, 32'hB6, 2'h0);
      wr(o + 8'h18, 32'hFF, 2'h0);
      rd(o + 8'h18, 32'hC0, 2'h0);
      rd(o + 8'h0C, 32'hB6, 2'h0);
      chk(out(i), 32'h7A5 + i);
    end
    wr(8'h24, 32'h13, 2'h0);
    @(negedge clock_in);
    for (int i = 0; i < 3; i++) begin
      chk(out(i), 32'h6DB);
      rd(8'h28 + 8'(4 * i), 32'h2DB, 2'h0);
    end
    $display("test left justified load done");
    @(posedge clock_in);
    rst_in <= 1'b1;
    @(negedge clock_in);
    for (int i = 0; i < 3; i++) chk(out(i), 32'h0);
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    $display("test mid-run reset done");
    slow_ready = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hA9, 2'h0);
      rd(8'(4 * i), 32'hA9, 2'h0);
      chk(pins(i), 32'h69);
    end
    slow_ready = 1'b0;
    s_axi_wstrb_in <= 4'hE;
    wr(8'h0C, 32'h03, 2'h0);
    s_axi_wstrb_in <= 4'hF;
    rd(8'h0C, 32'h0, 2'h0);
    wr(8'h28, 32'h3FF, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    chk(out(0), 32'h400);
    $display("test control pins done");
    print_verdict;
  end
endmodule
bind drb_code_buffer drb_code_buffer_chk chk_u (.*);
`default_nettype wire
